// file: pkg/cfgctl_pkg.sv
// constants and carrier types for the configuration-control pin block
package cfgctl_pkg;

	// ==========================================================
	// clock and timing
	// ==========================================================
	localparam real CLK_MHZ = 200.0; // reference clock rate
	localparam real REFRESH_MAX_MS = 2.3; // longest flash-to-sram load time
	// longest time rounds down to whole cycles
	localparam int REFRESH_CYC = $rtoi(REFRESH_MAX_MS * 1000.0 * CLK_MHZ);
	localparam int CLR_CYC = 4; // cycles ready is held low after power-up
	localparam int SCK_HALF_CYC = 4; // reference cycles per half master clock

	// ==========================================================
	// configuration modes captured from the mode pins
	// ==========================================================
	localparam logic [1:0] MODE_SLAVE_SPI = 2'h0;
	localparam logic [1:0] MODE_MASTER_SPI = 2'h1;
	localparam logic [1:0] MODE_FLASH_ONLY = 2'h2;
	localparam logic [1:0] MODE_RESERVED = 2'h3;
	localparam logic [1:0] MODE_RST = MODE_FLASH_ONLY; // mode before first capture

	// ==========================================================
	// master read header and slave status
	// ==========================================================
	localparam logic [31:0] FLASH_READ_HDR = 32'h0300_0000; // read opcode, address zero
	localparam int HDR_BITS = 32; // header length in bits
	localparam logic [6:0] SLAVE_STATUS_PAD = 7'h00; // upper bits of slave status

	// ==========================================================
	// sequencer states
	// ==========================================================
	typedef enum logic [1:0] {
		ST_CLEAR = 2'b00, // ready held low, request low or power-up
		ST_WAIT_READY = 2'b01, // ready released, waiting for the pin to rise
		ST_LOAD = 2'b10, // flash copied into configuration sram
		ST_DONE = 2'b11 // completion pin released, startup under way
	} cfgctl_state_t;

	// drive and enable of one pin; open-drain pins only ever drive low
	typedef struct packed {
		logic drive; // level driven while enabled
		logic oe; // high while this block drives the pin
	} cfgctl_pin_t;

	// received configuration byte with its one-cycle strobe
	typedef struct packed {
		logic [7:0] data; // byte value, msb first on the wire
		logic strobe; // one reference cycle per byte
	} cfgctl_byte_t;

endpackage : cfgctl_pkg

// file: verilog/cfgctl_pins.sv
// configuration-control pin sequencer with spi master and slave data paths
`timescale 1ns/100ps
`default_nettype none
module cfgctl_pins #(
	parameter int REFRESH_CYCLES = cfgctl_pkg::REFRESH_CYC // shorten for simulation
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic config_clock_in,
	output cfgctl_pkg::cfgctl_pin_t config_clock_out,
	input wire logic [1:0] config_mode_in,
	input wire logic config_request_n_in,
	input wire logic config_ready_n_in,
	output cfgctl_pkg::cfgctl_pin_t config_ready_n_out,
	output logic config_ready_pullup_out,
	output cfgctl_pkg::cfgctl_pin_t config_done_out,
	input wire logic spi_data_a_in,
	output cfgctl_pkg::cfgctl_pin_t spi_data_a_out,
	input wire logic spi_data_b_in,
	output cfgctl_pkg::cfgctl_pin_t spi_data_b_out,
	output logic flash_select_n_out,
	input wire logic slave_select_n_in,
	input wire logic io_output_enable_n_in,
	output logic user_io_hiz_out,
	output logic [1:0] config_mode_out,
	output cfgctl_pkg::cfgctl_byte_t config_byte_out
);
	import cfgctl_pkg::*;

	// ==========================================================
	// pin synchronisers
	// ==========================================================
	// order: select, oe, data b, ready, request, mode[1:0]
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] pins_raw; // raw pin levels
	logic [NSYNC-1:0] sync1_q; // first stage, read only by stage two
	logic [NSYNC-1:0] sync2_q; // settled levels
	assign pins_raw = {slave_select_n_in, io_output_enable_n_in, spi_data_b_in,
		config_ready_n_in, config_request_n_in, config_mode_in};

	// two flops per pin; reset to the pulled-up idle levels
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_q <= 7'h7C;
			sync2_q <= 7'h7C;
		end else begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
		end
	end

	logic sel_n_s, oe_n_s, data_b_s, ready_s, request_n_s; // synced levels
	logic [1:0] mode_s;
	assign {sel_n_s, oe_n_s, data_b_s, ready_s, request_n_s, mode_s} = sync2_q;

	// ==========================================================
	// configuration sequencer
	// ==========================================================
	cfgctl_state_t state_q; // sequencer state
	logic [31:0] timer_q; // clear hold and load time counter
	logic ready_prev_q; // ready level one cycle ago
	logic [1:0] mode_q; // captured configuration mode
	logic ready_rise; // ready pin has just risen
	assign ready_rise = ready_s && !ready_prev_q;

	// ready history for edge detection on the settled level
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ready_prev_q <= 1'b1; // matches the synchroniser's idle level, no false rise
		end else begin
			ready_prev_q <= ready_s;
		end
	end

	// reset enters clear, so power-up runs the same load as a request release
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= ST_CLEAR;
			timer_q <= 32'h0;
		end else if (!request_n_s) begin
			state_q <= ST_CLEAR;
			timer_q <= 32'h0;
		end else begin
			case (state_q)
				ST_CLEAR: begin
					// hold ready low a few cycles after the request goes high
					if (timer_q >= 32'(CLR_CYC - 1)) begin
						state_q <= ST_WAIT_READY;
						timer_q <= 32'h0;
					end else begin
						timer_q <= timer_q + 32'h1;
					end
				end
				ST_WAIT_READY: begin
					// an outside party may hold ready low to delay the load
					if (ready_rise) begin
						state_q <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (timer_q >= 32'(REFRESH_CYCLES - 1)) begin
						state_q <= ST_DONE;
					end else begin
						timer_q <= timer_q + 32'h1;
					end
				end
				default: begin
					state_q <= ST_DONE; // stays until the next request
				end
			endcase
		end
	end

	// mode pins latched only on the ready rising edge
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_q <= MODE_RST;
		end else if (state_q == ST_WAIT_READY && ready_rise) begin
			mode_q <= mode_s;
		end
	end

	// ==========================================================
	// status pins and user io control
	// ==========================================================
	// open-drain pins: drive low or release, never drive high
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			config_ready_n_out <= '{drive: 1'b0, oe: 1'b1};
			config_ready_pullup_out <= 1'b1;
			config_done_out <= '{drive: 1'b0, oe: 1'b1};
			user_io_hiz_out <= 1'b1;
			config_mode_out <= MODE_RST;
		end else begin
			config_ready_n_out <= '{drive: 1'b0, oe: (state_q == ST_CLEAR)};
			config_ready_pullup_out <= (state_q != ST_DONE);
			config_done_out <= '{drive: 1'b0, oe: (state_q != ST_DONE)};
			user_io_hiz_out <= !oe_n_s;
			config_mode_out <= mode_q;
		end
	end

	// ==========================================================
	// spi master toward external flash
	// ==========================================================
	logic master_act; // load running in master mode
	assign master_act = (state_q == ST_LOAD) && (mode_q == MODE_MASTER_SPI);
	logic [2:0] div_q; // half-period divider
	logic sck_q; // generated configuration clock
	logic [5:0] bit_q; // header bits sent
	logic [31:0] hdr_q; // outgoing header shift register
	logic [2:0] mbit_q; // received bit count within a byte
	logic [7:0] msh_q; // master receive shift register
	logic mbyte_q; // master byte complete, one cycle
	logic [7:0] mbyte_data_q; // completed master byte

	// clock divided from the reference; no second domain on this side
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_q <= 3'h0;
			sck_q <= 1'b0;
		end else if (!master_act) begin
			div_q <= 3'h0;
			sck_q <= 1'b0;
		end else if (div_q >= 3'(SCK_HALF_CYC - 1)) begin
			div_q <= 3'h0;
			sck_q <= !sck_q;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	logic sck_fall, sck_rise; // edges about to happen on the pin
	assign sck_fall = master_act && sck_q && div_q >= 3'(SCK_HALF_CYC - 1);
	assign sck_rise = master_act && !sck_q && div_q >= 3'(SCK_HALF_CYC - 1);

	// header shifts out msb first, changing on falling clock
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hdr_q <= FLASH_READ_HDR;
			bit_q <= 6'h0;
		end else if (!master_act) begin
			hdr_q <= FLASH_READ_HDR;
			bit_q <= 6'h0;
		end else if (sck_fall && bit_q < 6'(HDR_BITS)) begin
			hdr_q <= {hdr_q[30:0], 1'b0};
			bit_q <= bit_q + 6'h1;
		end
	end

	// after the header, data b is sampled on rising clock; bytes msb first
	// the synchroniser adds two reference cycles, well inside a half period
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			msh_q <= 8'h00;
			mbit_q <= 3'h0;
			mbyte_q <= 1'b0;
			mbyte_data_q <= 8'h00;
		end else begin
			mbyte_q <= 1'b0;
			if (!master_act) begin
				mbit_q <= 3'h0;
			end else if (sck_rise && bit_q == 6'(HDR_BITS)) begin
				msh_q <= {msh_q[6:0], data_b_s};
				mbit_q <= mbit_q + 3'h1;
				if (mbit_q == 3'h7) begin
					mbyte_q <= 1'b1;
					mbyte_data_q <= {msh_q[6:0], data_b_s};
				end
			end
		end
	end

	// ==========================================================
	// spi slave on the host clock
	// ==========================================================
	logic link_rst_n; // idle select clears the bit count between frames
	assign link_rst_n = rst_n_in && !slave_select_n_in;
	logic done_l1_q, done_l2_q; // completion level into the link domain
	logic [2:0] sbit_q; // slave bit count
	logic [7:0] ssh_q; // slave receive shift register
	logic [7:0] stx_q; // slave status shift register
	logic [7:0] sbyte_q; // last completed slave byte
	logic stog_q; // flips once per slave byte

	// completion level crosses with two flops
	always_ff @(posedge config_clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_l1_q <= 1'b0;
			done_l2_q <= 1'b0;
		end else begin
			done_l1_q <= !config_done_out.oe; // launched from a flop, no decode glitch
			done_l2_q <= done_l1_q;
		end
	end

	// bits in on data a, status out on data b, only while selected
	always_ff @(posedge config_clock_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			sbit_q <= 3'h0;
			ssh_q <= 8'h00;
			stx_q <= 8'h00;
		end else begin
			sbit_q <= sbit_q + 3'h1;
			ssh_q <= {ssh_q[6:0], spi_data_a_in};
			if (sbit_q == 3'h7) begin
				stx_q <= {SLAVE_STATUS_PAD, done_l2_q};
			end else begin
				stx_q <= {stx_q[6:0], 1'b0};
			end
		end
	end

	// byte and toggle survive deselect so the other domain can read them
	always_ff @(posedge config_clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sbyte_q <= 8'h00;
			stog_q <= 1'b0;
		end else if (!slave_select_n_in && sbit_q == 3'h7) begin
			sbyte_q <= {ssh_q[6:0], spi_data_a_in};
			stog_q <= !stog_q;
		end
	end

	// toggle synchroniser; byte is stable for a whole byte time after a flip
	logic stog1_q, stog2_q, stog3_q;
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stog1_q <= 1'b0;
			stog2_q <= 1'b0;
			stog3_q <= 1'b0;
		end else begin
			stog1_q <= stog_q;
			stog2_q <= stog1_q;
			stog3_q <= stog2_q;
		end
	end

	// ==========================================================
	// spi pin drives and received bytes
	// ==========================================================
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			config_clock_out <= '{drive: 1'b0, oe: 1'b0};
			spi_data_a_out <= '{drive: 1'b0, oe: 1'b0};
			spi_data_b_out <= '{drive: 1'b0, oe: 1'b0};
			flash_select_n_out <= 1'b1;
			config_byte_out <= '{data: 8'h00, strobe: 1'b0};
		end else begin
			config_clock_out <= '{drive: sck_q, oe: master_act};
			spi_data_a_out <= '{drive: hdr_q[31], oe: master_act};
			// data b comes from a slave-domain flop, re-registered on the reference clock, enabled by settled select
			spi_data_b_out <= '{drive: stx_q[7],
				oe: (mode_q == MODE_SLAVE_SPI) && !sel_n_s};
			flash_select_n_out <= !master_act;
			if (mbyte_q) begin
				config_byte_out <= '{data: mbyte_data_q, strobe: 1'b1};
			end else if (stog2_q != stog3_q) begin
				config_byte_out <= '{data: sbyte_q, strobe: 1'b1};
			end else begin
				config_byte_out <= '{data: config_byte_out.data, strobe: 1'b0};
			end
		end
	end

endmodule : cfgctl_pins
`default_nettype wire

// file: verification/cfgctl_flash_model.sv
// behavioural serial flash that answers the master read of the pin block
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// flash partner model
// ==========================================================
module cfgctl_flash_model (
	input wire logic sck_in, // configuration clock pin level
	input wire logic cs_n_in, // flash select pin level
	input wire logic mosi_in, // data a pin level
	output logic miso_out, // data b pin level
	output logic [31:0] hdr_out // first 32 bits seen after select
);
	int n = 0; // bits clocked since select fell
	logic [7:0] b; // byte being sent
	// line starts low, header store empty
	initial begin
		miso_out = 1'b0;
		hdr_out = 32'h0;
	end
	// header is taken on the rising clock while selected
	always @(posedge sck_in) begin
		if (!cs_n_in) begin
			if (n < 32) hdr_out = {hdr_out[30:0], mosi_in};
			n++;
		end
	end
	// data leaves after the falling clock; a released line must not keep its last value
	always @(negedge sck_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			miso_out = ~miso_out;
			n = 0;
		end else if (n >= 32) begin
			b = 8'h3C + 8'((n - 32) / 8 * 17);
			miso_out = b[7 - (n - 32) % 8];
		end
	end
endmodule : cfgctl_flash_model
`default_nettype wire

// file: verification/cfgctl_pins_properties.sv
// concurrent checks on the ports of the configuration-control pin block
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checker
// ==========================================================
module cfgctl_pins_properties import cfgctl_pkg::*; #(
	parameter int REFRESH_CYCLES = 1000 // load length in reference cycles
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic config_request_n_in,
	input wire logic config_ready_n_in,
	input wire logic io_output_enable_n_in,
	input wire cfgctl_pkg::cfgctl_pin_t config_clock_out,
	input wire cfgctl_pkg::cfgctl_pin_t config_ready_n_out,
	input wire cfgctl_pkg::cfgctl_pin_t config_done_out,
	input wire cfgctl_pkg::cfgctl_pin_t spi_data_a_out,
	input wire cfgctl_pkg::cfgctl_pin_t spi_data_b_out,
	input wire logic flash_select_n_out,
	input wire logic user_io_hiz_out,
	input wire logic [1:0] config_mode_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [31:0] up_q; // cycles the ready pin has stood high
	// counts from the ready rise so the load time can be bounded
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) up_q <= 32'h0;
		else if (config_ready_n_in) up_q <= up_q + 32'h1;
		else up_q <= 32'h0;
	end
	a_open_drain_low: assert property (
		!config_done_out.drive && !config_ready_n_out.drive) else $error("open-drain driven high");
	a_request_aborts: assert property (
		!config_request_n_in [*5] |-> config_done_out.oe) else $error("done kept after request");
	a_request_holds_rdy: assert property (
		!config_request_n_in [*5] |-> config_ready_n_out.oe) else $error("ready not held");
	a_hiz_on_enable: assert property (
		!io_output_enable_n_in [*4] |-> user_io_hiz_out) else $error("user io not tristated");
	a_hiz_off_enable: assert property (
		io_output_enable_n_in [*4] |-> !user_io_hiz_out) else $error("user io tristated");
	a_mode_at_ready: assert property (
		$changed(config_mode_out) |-> config_ready_n_in) else $error("mode moved off ready rise");
	a_select_master: assert property (
		!flash_select_n_out |-> config_mode_out == MODE_MASTER_SPI) else $error("stray select");
	a_clock_master: assert property (
		config_clock_out.oe |-> !flash_select_n_out) else $error("clock driven outside master");
	a_data_a_dir: assert property (
		spi_data_a_out.oe |-> config_mode_out == MODE_MASTER_SPI) else $error("data a driven");
	a_data_b_dir: assert property (
		spi_data_b_out.oe |-> config_mode_out == MODE_SLAVE_SPI) else $error("data b driven");
	a_load_time: assert property (
		$fell(config_done_out.oe) |-> up_q >= REFRESH_CYCLES && up_q <= REFRESH_CYCLES + 8)
		else $error("load time off");
endmodule : cfgctl_pins_properties
bind cfgctl_pins cfgctl_pins_properties #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_props (
	.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .config_request_n_in(config_request_n_in),
	.config_ready_n_in(config_ready_n_in), .io_output_enable_n_in(io_output_enable_n_in),
	.config_clock_out(config_clock_out), .config_ready_n_out(config_ready_n_out),
	.config_done_out(config_done_out), .spi_data_a_out(spi_data_a_out),
	.spi_data_b_out(spi_data_b_out), .flash_select_n_out(flash_select_n_out),
	.user_io_hiz_out(user_io_hiz_out), .config_mode_out(config_mode_out));
`default_nettype wire

// file: verification/cfgctl_pins_tb.sv
// self-checking bench of the configuration-control pin block
`timescale 1ns/100ps
`default_nettype none
module cfgctl_pins_tb;
	import cfgctl_pkg::*;
	localparam int RC = 1000; // shortened load length
	logic ref_clk_in, rst_n_in, host_clk, host_a, host_sel_n, req_n, oe_n, hiz, fsel_n, flash_b;
	logic pull; // ready pin pull-up enable
	logic [1:0] mode, mode_o;
	logic [7:0] v; // random stimulus byte
	logic [31:0] hdr; // header the flash saw
	cfgctl_pin_t cko, rdy, done, da, db;
	cfgctl_byte_t byt;
	int error_cnt, checks, cyc, seed, t0, w;
	logic [7:0] got[$], exp[$]; // bytes seen and bytes predicted
	// pin levels: clock, data a and ready resolved from whoever drives them, pull-up on ready; data b comes from the flash alone
	wire clk_pin = cko.oe ? cko.drive : host_clk;
	wire a_pin = da.oe ? da.drive : host_a;
	wire rdy_pin = !rdy.oe;
	cfgctl_pins #(.REFRESH_CYCLES(RC)) dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.config_clock_in(clk_pin), .config_clock_out(cko), .config_mode_in(mode),
		.config_request_n_in(req_n), .config_ready_n_in(rdy_pin), .config_ready_n_out(rdy),
		.config_ready_pullup_out(pull), .config_done_out(done), .spi_data_a_in(a_pin),
		.spi_data_a_out(da), .spi_data_b_in(flash_b), .spi_data_b_out(db),
		.flash_select_n_out(fsel_n), .slave_select_n_in(host_sel_n),
		.io_output_enable_n_in(oe_n), .user_io_hiz_out(hiz), .config_mode_out(mode_o),
		.config_byte_out(byt));
	// no test access port is modelled, so the test clock stays idle in master mode
	cfgctl_flash_model u_flash (.sck_in(clk_pin), .cs_n_in(fsel_n), .mosi_in(a_pin),
		.miso_out(flash_b), .hdr_out(hdr));
	// ==========================================================
	// helpers
	// ==========================================================
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	// host sends one byte msb first on its own 125 ns clock
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			host_a = b[i];
			#62.5 host_clk = 1'b1;
			#62.5 host_clk = 1'b0;
		end
		host_a = ~host_a; // released line must not hold the last bit
	endtask : send
	// reference clock
	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	// byte collector and hang limit
	always @(posedge ref_clk_in) begin
		cyc++;
		if (byt.strobe === 1'b1) got.push_back(byt.data);
		if (cyc == 60000) begin
			error_cnt++;
			wrap_up();
		end
	end
	// ==========================================================
	// main sequence
	// ==========================================================
	initial begin
		seed = 32'h6555_9C9B;
		{error_cnt, checks, cyc} = '0;
		{rst_n_in, host_clk, host_a} = 3'h0;
		{host_sel_n, req_n, oe_n} = 3'h7;
		mode = 2'h2;
		repeat (4) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			v = 8'($random(seed));
			oe_n <= v[0];
			repeat (5) @(posedge ref_clk_in);
			chk(32'(hiz), 32'(!v[0]));
		end
		$display("tristate test done");
		for (int m = 0; m < 4; m++) begin
			mode <= 2'(m);
			req_n <= 1'b0;
			repeat (8) @(posedge ref_clk_in);
			chk(32'(done.oe), 32'h1);
			chk(32'(pull), 32'h1);
			got.delete();
			exp.delete();
			req_n <= 1'b1;
			w = 0;
			while (rdy.oe !== 1'b0 && w < 100) begin
				@(posedge ref_clk_in);
				w++;
			end
			t0 = cyc;
			repeat (10) @(posedge ref_clk_in);
			mode <= 2'($random(seed)); // must be ignored after capture
			if (m == 0) begin
				host_sel_n <= 1'b0;
				#1.3;
				for (int k = 0; k < 3; k++) begin
					v = 8'($random(seed));
					exp.push_back(v);
					send(v);
				end
				@(posedge ref_clk_in);
				host_sel_n <= 1'b1;
			end
			if (m == 1) for (int k = 0; k < 3; k++) exp.push_back(8'h3C + 8'(k * 17));
			w = 0;
			while (done.oe !== 1'b0 && w < 3000) begin
				@(posedge ref_clk_in);
				w++;
			end
			chk(32'(cyc - t0 >= RC && cyc - t0 <= RC + 8), 32'h1);
			chk(32'(mode_o), 32'(m));
			chk(32'(pull), 32'h0);
			if (m == 1) chk(hdr, FLASH_READ_HDR);
			if (m < 2) begin
				chk(32'(got.size() >= 3), 32'h1);
				for (int k = 0; k < 3; k++) chk(32'(got[k]), 32'(exp[k]));
			end else chk(32'(got.size()), 32'h0);
			$display("mode %0d test done", m);
		end
		rst_n_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		chk(32'({rdy.oe, done.oe, hiz}), 32'h7);
		$display("reset test done");
		wrap_up();
	end
endmodule : cfgctl_pins_tb
`default_nettype wire
